// ### rtl/tdc_dma.sv
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "tdc_defines.svh"

// Overview of operation
// - channel zero beats channel one when both pending
// - each unit is eight or sixteen bits
// - addresses advance or stay; never both advance
// - single mode stops channel at counter underflow
// - repeat mode reloads counter, channel stays active
// - interrupt raised at each counter underflow
// - one unit moved per transfer request
// - sources: serial, sync serial, software triggers
// - sources also include timers, serial paths
// - source on both edges of external irq
module tdc_dma import tdc_pkg::*; #(
  parameter int AW = 24,
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [12:0] periph_req,
  input wire logic external_irq_zero,
  input wire logic external_irq_one,
  output logic [AW-1:0] mem_address,
  output logic mem_read,
  output logic mem_write,
  output logic [15:0] mem_writedata,
  output logic [1:0] mem_byteenable,
  input wire logic [15:0] mem_readdata,
  input wire logic mem_waitrequest,
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  logic [AW-1:0] src_r [2], src_nxt [2]; // source address
  logic [AW-1:0] dst_r [2], dst_nxt [2]; // destination address
  logic [CW-1:0] rld_r [2], rld_nxt [2]; // reload value
  logic [CW-1:0] cnt_r [2], cnt_nxt [2]; // live counter
  logic [`TDC_CTRL_W-1:0] ctl_r [2], ctl_nxt [2]; // control bits
  logic [3:0] sel_r [2], sel_nxt [2]; // request source select
  logic [1:0] pend_r, pend_nxt; // latched requests
  logic [1:0] stat_r, stat_nxt; // sticky underflow flags
  logic [1:0] mask_r, mask_nxt; // interrupt mask
  logic irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;
  tdc_state_e st_r, st_nxt;
  tdc_ch_t ch_r, ch_nxt; // channel being served
  logic [AW-1:0] maddr_r, maddr_nxt;
  logic mrd_r, mrd_nxt, mwr_r, mwr_nxt;
  logic [15:0] mwd_r, mwd_nxt;
  logic [1:0] mbe_r, mbe_nxt;
  logic ext0_q_r, ext1_q_r; // previous external irq levels

  // ****************************************
  // helpers
  // ****************************************
  // merge a bus write into a register under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  // byte lanes of a unit at an address
  function automatic logic [1:0] lanes(input logic u16,
                                       input logic a0);
    return u16 ? 2'h3 : (a0 ? 2'h2 : 2'h1);
  endfunction : lanes
  // address step after a unit: fixed, one or two bytes
  function automatic logic [AW-1:0] step(input logic [AW-1:0] a,
                                         input logic fwd,
                                         input logic u16);
    // a fixed address keeps its value; forward adds the unit size
    return fwd ? a + (u16 ? AW'(2) : AW'(1)) : a;
  endfunction : step
  // ****************************************
  // request events
  // ****************************************
  logic [15:0] evt; // one bit per source code
  logic [1:0] hit; // selected event per channel
  logic done, uf;
  logic [6:0] loc; // offset inside a channel block
  tdc_ch_t bch; // channel addressed by the bus
  logic wr_go, rd_go;
  always_comb begin
    evt = {periph_req, 3'h0};
    // external irq inputs count on both edges
    evt[`TDC_SEL_EXT0] = external_irq_zero ^ ext0_q_r;
    evt[`TDC_SEL_EXT1] = external_irq_one ^ ext1_q_r;
    for (int c = 0; c < 2; c++) begin
      // timers, serial and sync serial units land at their codes
      hit[c] = evt[sel_r[c]] && ctl_r[c][`TDC_CTRL_EN];
    end
  end
  assign done = (st_r == TDC_WR) && !mem_waitrequest;
  assign uf = done && (cnt_r[ch_r] == '0);
  assign bch = tdc_ch_t'(avs_address[5]);
  assign loc = {2'h0, avs_address[4:0]};
  assign wr_go = avs_write && !wait_r && !avs_address[6];
  assign rd_go = avs_read && wait_r;
  // ****************************************
  // register bus and channel engine
  // ****************************************
  // next-state values except pending, status and irq; bus writes first, engine updates override
  always_comb begin
    logic [31:0] cw;
    logic [CW-1:0] c;
    cw = 32'h0;
    c = '0;
    src_nxt = src_r;
    dst_nxt = dst_r;
    rld_nxt = rld_r;
    cnt_nxt = cnt_r;
    ctl_nxt = ctl_r;
    sel_nxt = sel_r;
    mask_nxt = mask_r;
    st_nxt = st_r;
    ch_nxt = ch_r;
    maddr_nxt = maddr_r;
    mrd_nxt = mrd_r;
    mwr_nxt = mwr_r;
    mwd_nxt = mwd_r;
    mbe_nxt = mbe_r;
    // one wait cycle, then answer; write lands at the answering edge
    wait_nxt = !((avs_read || avs_write) && wait_r);
    rdata_nxt = rdata_r;
    if (rd_go) begin
      if (avs_address[6]) begin
        case (avs_address)
          `TDC_OFS_STAT: rdata_nxt = {30'h0, stat_r};
          `TDC_OFS_MASK: rdata_nxt = {30'h0, mask_r};
          default: rdata_nxt = 32'h0;
        endcase
      end else begin
        case (loc)
          `TDC_OFS_SRC: rdata_nxt = 32'(src_r[bch]);
          `TDC_OFS_DST: rdata_nxt = 32'(dst_r[bch]);
          `TDC_OFS_RLD: rdata_nxt = 32'(rld_r[bch]);
          `TDC_OFS_CNT: rdata_nxt = 32'(cnt_r[bch]);
          `TDC_OFS_CTRL: rdata_nxt = 32'(ctl_r[bch]);
          `TDC_OFS_SEL: rdata_nxt = {28'h0, sel_r[bch]};
          default: rdata_nxt = 32'h0;
        endcase
      end
    end
    if (avs_write && !wait_r && avs_address == `TDC_OFS_MASK) begin
      mask_nxt = 2'(merge(32'(mask_r), avs_writedata, avs_byteenable));
    end
    if (wr_go) begin
      case (loc)
        `TDC_OFS_SRC: src_nxt[bch] = AW'(merge(32'(src_r[bch]),
                                       avs_writedata, avs_byteenable));
        `TDC_OFS_DST: dst_nxt[bch] = AW'(merge(32'(dst_r[bch]),
                                       avs_writedata, avs_byteenable));
        `TDC_OFS_RLD: rld_nxt[bch] = CW'(merge(32'(rld_r[bch]),
                                       avs_writedata, avs_byteenable));
        `TDC_OFS_CNT: cnt_nxt[bch] = CW'(merge(32'(cnt_r[bch]),
                                       avs_writedata, avs_byteenable));
        `TDC_OFS_CTRL: begin
          cw = merge(32'(ctl_r[bch]), avs_writedata, avs_byteenable);
          // both addresses advancing is refused: old control stays
          if (!(cw[`TDC_CTRL_SFWD] && cw[`TDC_CTRL_DFWD])) begin
            ctl_nxt[bch] = cw[`TDC_CTRL_W-1:0];
          end
        end
        `TDC_OFS_SEL: sel_nxt[bch] = 4'(merge(32'(sel_r[bch]),
                                       avs_writedata, avs_byteenable));
        default: ;
      endcase
    end
    // engine: one unit per grant, read then write
    case (st_r)
      TDC_IDLE: begin
        if (pend_r != 2'h0) begin
          ch_nxt = tdc_ch_t'(!pend_r[0]);
          st_nxt = TDC_RD;
          maddr_nxt = src_r[ch_nxt];
          mrd_nxt = 1'b1;
          mbe_nxt = lanes(ctl_r[ch_nxt][`TDC_CTRL_U16],
                          src_r[ch_nxt][0]);
        end
      end
      TDC_RD: begin
        if (!mem_waitrequest) begin
          mrd_nxt = 1'b0;
          mwr_nxt = 1'b1;
          st_nxt = TDC_WR;
          maddr_nxt = dst_r[ch_r];
          mbe_nxt = lanes(ctl_r[ch_r][`TDC_CTRL_U16], dst_r[ch_r][0]);
          mwd_nxt = mem_readdata;
          // a byte is moved to whichever lane the destination uses
          if (!ctl_r[ch_r][`TDC_CTRL_U16]) begin
            mwd_nxt = src_r[ch_r][0] ? {2{mem_readdata[15:8]}}
                                     : {2{mem_readdata[7:0]}};
          end
        end
      end
      TDC_WR: begin
        if (!mem_waitrequest) begin
          mwr_nxt = 1'b0;
          st_nxt = TDC_IDLE;
          src_nxt[ch_r] = step(src_r[ch_r], ctl_r[ch_r][`TDC_CTRL_SFWD],
                               ctl_r[ch_r][`TDC_CTRL_U16]);
          dst_nxt[ch_r] = step(dst_r[ch_r], ctl_r[ch_r][`TDC_CTRL_DFWD],
                               ctl_r[ch_r][`TDC_CTRL_U16]);
          c = cnt_r[ch_r];
          if (c == '0) begin
            if (ctl_r[ch_r][`TDC_CTRL_RPT]) begin
              cnt_nxt[ch_r] = rld_r[ch_r];
            end else begin
              cnt_nxt[ch_r] = '1; // counter wraps on underflow
              ctl_nxt[ch_r][`TDC_CTRL_EN] = 1'b0;
            end
          end else begin
            cnt_nxt[ch_r] = c - CW'(1);
          end
        end
      end
      default: st_nxt = TDC_IDLE;
    endcase
    // software trigger bit never stores
    ctl_nxt[0][`TDC_CTRL_SWTRIG] = 1'b0;
    ctl_nxt[1][`TDC_CTRL_SWTRIG] = 1'b0;
  end
  // pending requests: a new request wins over the clear at grant;
  // a request arriving mid-unit is kept, not merged, once the unit ends, unless a single-mode underflow disables the channel
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      pend_nxt[c] = pend_r[c];
      if (st_r == TDC_IDLE && pend_r != 2'h0 && ch_nxt == tdc_ch_t'(c)) begin
        pend_nxt[c] = 1'b0; // granted: the request is consumed
      end
      if (!ctl_nxt[c][`TDC_CTRL_EN]) begin
        pend_nxt[c] = 1'b0;
      end
      if (hit[c] || (wr_go && bch == tdc_ch_t'(c) && loc == `TDC_OFS_CTRL &&
                     avs_byteenable[0] &&
                     avs_writedata[`TDC_CTRL_SWTRIG])) begin
        pend_nxt[c] = ctl_nxt[c][`TDC_CTRL_EN];
      end
    end
  end
  // ****************************************
  // interrupt
  // ****************************************
  // underflow sets its flag; a write of one clears, the set wins
  always_comb begin
    stat_nxt = stat_r;
    if (avs_write && !wait_r && avs_address == `TDC_OFS_STAT &&
        avs_byteenable[0]) begin
      stat_nxt = stat_r & ~avs_writedata[1:0];
    end
    if (uf) begin
      stat_nxt[ch_r] = 1'b1;
    end
    irq_nxt = |(stat_nxt & mask_r);
  end
  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int c = 0; c < 2; c++) begin
        src_r[c] <= '0;
        dst_r[c] <= '0;
        rld_r[c] <= '0;
        cnt_r[c] <= '0;
        ctl_r[c] <= `TDC_RST_CTRL;
        sel_r[c] <= `TDC_RST_SEL;
      end
      pend_r <= 2'h0;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      irq_r <= 1'b0;
      rdata_r <= 32'h0;
      wait_r <= 1'b1;
      st_r <= TDC_IDLE;
      ch_r <= 1'b0;
      maddr_r <= '0;
      mrd_r <= 1'b0;
      mwr_r <= 1'b0;
      mwd_r <= 16'h0;
      mbe_r <= 2'h0;
      ext0_q_r <= 1'b0;
      ext1_q_r <= 1'b0;
    end else begin
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      rld_r <= rld_nxt;
      cnt_r <= cnt_nxt;
      ctl_r <= ctl_nxt;
      sel_r <= sel_nxt;
      pend_r <= pend_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      st_r <= st_nxt;
      ch_r <= ch_nxt;
      maddr_r <= maddr_nxt;
      mrd_r <= mrd_nxt;
      mwr_r <= mwr_nxt;
      mwd_r <= mwd_nxt;
      mbe_r <= mbe_nxt;
      ext0_q_r <= external_irq_zero;
      ext1_q_r <= external_irq_one;
    end
  end
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign mem_address = maddr_r;
  assign mem_read = mrd_r;
  assign mem_write = mwr_r;
  assign mem_writedata = mwd_r;
  assign mem_byteenable = mbe_r;
  assign irq = irq_r;
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence unit_end_s;
    (st_r == TDC_WR) && !mem_waitrequest;
  endsequence
  prio_zero_a: assert property ((st_r == TDC_IDLE && pend_r == 2'h3)
    |=> (ch_r == 1'b0 && mem_read)) else $error("channel one won");
  unit_lane_a: assert property ((mem_read || mem_write)
    |-> (ctl_r[ch_r][`TDC_CTRL_U16] ? mem_byteenable == 2'h3
         : $onehot(mem_byteenable))) else $error("bad unit lanes");
  dir_both_a: assert property (!(ctl_r[0][`TDC_CTRL_SFWD] &&
    ctl_r[0][`TDC_CTRL_DFWD]) && !(ctl_r[1][`TDC_CTRL_SFWD] &&
    ctl_r[1][`TDC_CTRL_DFWD])) else $error("both forward");
  single_stop_a: assert property ((uf && !ctl_r[ch_r][`TDC_CTRL_RPT])
    |=> !ctl_r[$past(ch_r)][`TDC_CTRL_EN]) else $error("no stop");
  repeat_load_a: assert property ((uf && ctl_r[ch_r][`TDC_CTRL_RPT]
    && !avs_write) |=> (cnt_r[$past(ch_r)] == $past(rld_r[ch_r]) &&
    ctl_r[$past(ch_r)][`TDC_CTRL_EN])) else $error("no reload");
  irq_flag_a: assert property (uf |=> stat_r[$past(ch_r)])
    else $error("underflow flag missing");
  one_unit_a: assert property (unit_end_s |=> (st_r == TDC_IDLE &&
    !mem_read && !mem_write)) else $error("burst seen");
  src_hit_a: assert property ((hit[0] && !avs_write && !done)
    |=> pend_r[0] || st_r == TDC_RD) else $error("request lost");
  cnt_dec_a: assert property ((unit_end_s and (cnt_r[ch_r] != '0)
    and !avs_write) |=> cnt_r[$past(ch_r)] ==
    $past(cnt_r[ch_r]) - CW'(1)) else $error("count not stepped");
endmodule : tdc_dma

// ### rtl/tdc_defines.svh
`ifndef TDC_DEFINES_SVH
`define TDC_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define TDC_CH_STRIDE 7'h20
`define TDC_OFS_SRC 7'h00
`define TDC_OFS_DST 7'h04
`define TDC_OFS_RLD 7'h08
`define TDC_OFS_CNT 7'h0c
`define TDC_OFS_CTRL 7'h10
`define TDC_OFS_SEL 7'h14
`define TDC_OFS_STAT 7'h40
`define TDC_OFS_MASK 7'h44

// ****************************************
// control field positions
// ****************************************
`define TDC_CTRL_EN 0
`define TDC_CTRL_U16 1
`define TDC_CTRL_SFWD 2
`define TDC_CTRL_DFWD 3
`define TDC_CTRL_RPT 4
`define TDC_CTRL_SWTRIG 5
`define TDC_CTRL_W 5

// ****************************************
// request source codes and reset values
// ****************************************
`define TDC_SEL_SOFT 4'h0
`define TDC_SEL_EXT0 4'h1
`define TDC_SEL_EXT1 4'h2
`define TDC_PERIPH_BASE 3
`define TDC_RST_CTRL 5'h00
`define TDC_RST_SEL 4'h0

`endif

// ### rtl/tdc_pkg.sv
package tdc_pkg;
  // transfer engine states
  typedef enum logic [1:0] {TDC_IDLE, TDC_RD, TDC_WR} tdc_state_e;
  // channel index
  typedef logic tdc_ch_t;
endpackage : tdc_pkg

// ### bench/tdc_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// memory slave on the far side of the engine
// ****************************************
module tdc_mem_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [23:0] mem_address,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [15:0] mem_writedata,
  input wire logic [1:0] mem_byteenable,
  output logic [15:0] mem_readdata,
  output logic mem_waitrequest,
  input wire logic slow,
  output int writes
);
  logic [7:0] mem [256]; // byte store, upper address bits ignored
  logic [1:0] wait_r; // cycles the current request has waited
  logic [15:0] last_r; // last word handed out
  logic [7:0] lo; // even byte of the addressed word
  logic ack; // request answered in this cycle
  assign lo = {mem_address[7:1], 1'b0};
  // slow mode stalls three cycles so held requests are exercised
  assign ack = (mem_read | mem_write) && wait_r == (slow ? 2'h3 : 2'h0);
  assign mem_waitrequest = !ack;
  // outside an answer the lines show the inverse of the last word,
  // so a sample taken at the wrong edge is caught
  assign mem_readdata = (mem_read && ack) ? {mem[lo + 8'h01], mem[lo]}
                                          : ~last_r;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
  end
  // wait counting, byte-lane writes and the unit counter
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 2'h0;
      last_r <= 16'h0000;
      writes <= 0;
    end else if (ack) begin
      wait_r <= 2'h0;
      last_r <= mem_readdata;
      if (mem_write) begin
        writes <= writes + 1;
        if (mem_byteenable[0]) mem[lo] <= mem_writedata[7:0];
        if (mem_byteenable[1]) mem[lo + 8'h01] <= mem_writedata[15:8];
      end
    end else if (mem_read | mem_write) begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule : tdc_mem_model

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, irq, slow;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [12:0] periph_req;
  logic external_irq_zero, external_irq_one;
  logic [23:0] mem_address;
  logic mem_read, mem_write, mem_waitrequest;
  logic [15:0] mem_writedata, mem_readdata;
  logic [1:0] mem_byteenable;
  int units, num_errors, num_checks, exp_cnt, u, n;
  tdc_dma uut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .periph_req, .external_irq_zero, .external_irq_one, .mem_address,
    .mem_read, .mem_write, .mem_writedata, .mem_byteenable, .mem_readdata,
    .mem_waitrequest, .irq);
  tdc_mem_model mem_i (.clk, .reset_n, .mem_address, .mem_read,
    .mem_write, .mem_writedata, .mem_byteenable, .mem_readdata,
    .mem_waitrequest, .slow, .writes(units));
  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [6:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      num_errors++;
      $display("wrong value at %0t: bus answer never came", $time);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [6:0] a, input logic [31:0] e,
                       input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, e, what);
  endtask : rdchk
  // wait for the unit total, then make sure no extra unit follows
  task automatic wait_units(input int target);
    n = 0;
    while (units != target && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    chk(units, target, "unit total");
  endtask : wait_units
  task automatic pulse(input logic [12:0] b);
    @(posedge clk);
    periph_req <= b;
    @(posedge clk);
    periph_req <= 13'h0000;
  endtask : pulse
  // ****************************************
  // clock, watchdog and test sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // whole run is about a thousand cycles; this is far beyond it
  initial begin
    #200000;
    num_errors++;
    print_verdict;
  end
  // directed test sequence: each trigger is followed by a check of its expected result
  initial begin
    {avs_read, avs_write, slow, external_irq_zero, external_irq_one} = 5'h00;
    avs_address = 7'h00;
    avs_writedata = 32'h0;
    periph_req = 13'h0000;
    reset_n = 1'b0;
    repeat (8) @(posedge clk);
    chk(avs_waitrequest, 1'b1, "wait in reset");
    reset_n <= 1'b1;
    // channel zero: 16-bit, source forward, single, software trigger
    wr(7'h00, 32'h10);
    wr(7'h04, 32'h80);
    wr(7'h0c, 32'h1);
    wr(7'h10, 32'h27);
    wait_units(1);
    chk({mem_i.mem[8'h81], mem_i.mem[8'h80]}, 16'hb4b5, "word one");
    wr(7'h10, 32'h27);
    wait_units(2);
    chk({mem_i.mem[8'h81], mem_i.mem[8'h80]}, 16'hb6b7, "word two");
    rdchk(7'h40, 32'h1, "status");
    rdchk(7'h10, 32'h6, "control");
    rdchk(7'h0c, 32'hffff, "count");
    rdchk(7'h00, 32'h14, "source");
    rdchk(7'h04, 32'h80, "destination");
    wr(7'h10, 32'h26);
    wait_units(2);
    chk(irq, 1'b0, "irq masked");
    wr(7'h44, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1, "irq raised");
    wr(7'h40, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq cleared");
    // channel one: byte units, destination forward, repeat, timer zero
    wr(7'h20, 32'h21);
    wr(7'h24, 32'h40);
    wr(7'h28, 32'h2);
    wr(7'h2c, 32'h0);
    wr(7'h34, 32'h3);
    wr(7'h30, 32'h19);
    pulse(13'h0001);
    wait_units(3);
    chk(mem_i.mem[8'h40], 8'h84, "byte unit");
    rdchk(7'h40, 32'h2, "status");
    rdchk(7'h30, 32'h19, "control");
    rdchk(7'h2c, 32'h2, "reloaded");
    rdchk(7'h24, 32'h41, "destination");
    chk(irq, 1'b0, "irq masked");
    wr(7'h40, 32'h2);
    // every peripheral source: others must not start a unit
    exp_cnt = 2;
    u = 3;
    for (int c = 3; c < 16; c++) begin
      slow <= c[0];
      wr(7'h34, 32'(c));
      pulse(~(13'h0001 << (c - 3)));
      wait_units(u);
      pulse(13'h0001 << (c - 3));
      u++;
      wait_units(u);
      exp_cnt = (exp_cnt == 0) ? 2 : exp_cnt - 1;
      rdchk(7'h2c, 32'(exp_cnt), "count");
    end
    // both edges of each external line
    for (int e = 0; e < 2; e++) begin
      wr(7'h34, 32'(e + 1));
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        if (e == 0) begin
          external_irq_zero <= !external_irq_zero;
        end else begin
          external_irq_one <= !external_irq_one;
        end
        u++;
        wait_units(u);
      end
    end
    // both channels on one request: channel zero goes first
    wr(7'h34, 32'h3);
    wr(7'h14, 32'h3);
    wr(7'h0c, 32'h5);
    wr(7'h10, 32'h7);
    pulse(13'h0001);
    n = 0;
    while (mem_read !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(mem_address, 24'h14, "first source");
    u += 2;
    wait_units(u);
    // both addresses forward is refused whole
    wr(7'h10, 32'h0d);
    rdchk(7'h10, 32'h7, "control kept");
    print_verdict;
  end
endmodule : testbench
